/* hdl/rtc_control_status_regs.sv */
// Control, status, flag and shared-byte registers of the 16-bit counter.
// Assumes a byte register port on i_clock and a slow counter clock pin.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module rtc_control_status_regs
  import rtc_pkg::*;
#(
  parameter int unsigned PPM_CYCLES = PPM_INTERVAL
)(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // System
  input  wire logic              i_counter_clk,
  input  wire logic              i_standby,
  input  wire logic              i_cpu_halted,
  // Requests, events, clock source and periodic control
  output logic                   o_irq_req,
  output logic                   o_wrap_evt,
  output logic                   o_match_evt,
  output logic      [1:0]        o_clk_source,
  output logic      [7:0]        o_periodic_ctrl
);
  rtc_tick_if tick_bus ();

  counter_clk_sync u_sync (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .i_pin    (i_counter_clk),
    .bus      (tick_bus.src)
  );

  prescaler_corr #(
    .PPM_CYCLES (PPM_CYCLES)
  ) u_presc (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_clk_en (i_clk_en),
    .bus      (tick_bus.presc)
  );

  function automatic logic [7:0] masked(input logic [7:0] d,
                                        input logic [7:0] m);
    return d & m;
  endfunction

  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_eff_q;
  logic [7:0]  ien_q;
  logic [7:0]  flags_q;
  logic [7:0]  shared_q;
  logic [7:0]  halt_q;
  logic [7:0]  freq_correction_q;
  logic [7:0]  source_q;
  logic [7:0]  pit_ctrl_q;
  logic [7:0]  pit_ien_q;
  logic [7:0]  pit_halt_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_load_q;
  logic [15:0] limit_q;
  logic [15:0] limit_eff_q;
  logic [15:0] match_q;
  logic [15:0] match_eff_q;
  logic [3:0]  busy_q;
  logic [1:0]  age_q [4];
  logic [7:0]  rdata_q;
  logic [7:0]  rd_d;
  logic        wrap_q;
  logic        match_evt_q;

  logic        wr_ctrl;
  logic        wr_ien;
  logic        wr_flags;
  logic        wr_shared;
  logic        wr_halt;
  logic        wr_freq_correction;
  logic        wr_source;
  logic        wr_lo;
  logic        wr_pit_ctrl;
  logic        wr_pit_ien;
  logic        wr_pit_halt;
  logic        rd_cnt_lo;
  logic        rd_limit_lo;
  logic        rd_match_lo;
  logic [3:0]  wr_ch;
  logic [3:0]  apply;
  logic        advance;
  logic [15:0] cnt_nxt;
  logic        wrap_hit;
  logic        match_hit;

  // Write and side-effect decode
  always_comb begin
    wr_ctrl     = 1'b0;
    wr_ien      = 1'b0;
    wr_flags    = 1'b0;
    wr_shared   = 1'b0;
    wr_halt     = 1'b0;
    wr_freq_correction    = 1'b0;
    wr_source   = 1'b0;
    wr_lo       = 1'b0;
    wr_pit_ctrl = 1'b0;
    wr_pit_ien  = 1'b0;
    wr_pit_halt = 1'b0;
    wr_ch       = 4'h0;
    if (i_wr && i_clk_en) begin
      if (i_addr == OFF_CTRL) begin
        wr_ctrl = 1'b1;
        wr_ch[CH_CTRL] = 1'b1;
      end else if (i_addr == OFF_IRQ_EN) begin
        wr_ien = 1'b1;
      end else if (i_addr == OFF_IRQ_FLAGS) begin
        wr_flags = 1'b1;
      end else if (i_addr == OFF_SHARED) begin
        wr_shared = 1'b1;
      end else if (i_addr == OFF_HALT) begin
        wr_halt = 1'b1;
      end else if (i_addr == OFF_FREQ_CORRECTION) begin
        wr_freq_correction = 1'b1;
      end else if (i_addr == OFF_SOURCE) begin
        wr_source = 1'b1;
      end else if (i_addr == OFF_COUNT_LO || i_addr == OFF_LIMIT_LO ||
                   i_addr == OFF_MATCH_LO) begin
        wr_lo = 1'b1;
      end else if (i_addr == OFF_COUNT_HI) begin
        wr_ch[CH_COUNT] = 1'b1;
      end else if (i_addr == OFF_LIMIT_HI) begin
        wr_ch[CH_LIMIT] = 1'b1;
      end else if (i_addr == OFF_MATCH_HI) begin
        wr_ch[CH_MATCH] = 1'b1;
      end else if (i_addr == OFF_PIT_CTRL) begin
        wr_pit_ctrl = 1'b1;
      end else if (i_addr == OFF_PIT_IEN) begin
        wr_pit_ien = 1'b1;
      end else if (i_addr == OFF_PIT_HALT) begin
        wr_pit_halt = 1'b1;
      end
    end
  end

  assign rd_cnt_lo   = i_rd && i_clk_en && (i_addr == OFF_COUNT_LO);
  assign rd_limit_lo = i_rd && i_clk_en && (i_addr == OFF_LIMIT_LO);
  assign rd_match_lo = i_rd && i_clk_en && (i_addr == OFF_MATCH_LO);

  // Software-side registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q     <= BYTE_RST;
      ien_q      <= BYTE_RST;
      halt_q     <= BYTE_RST;
      freq_correction_q    <= BYTE_RST;
      source_q   <= BYTE_RST;
      pit_ctrl_q <= BYTE_RST;
      pit_ien_q  <= BYTE_RST;
      pit_halt_q <= BYTE_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= masked(i_wdata, CTRL_MASK);
      if (wr_ien) ien_q <= masked(i_wdata, IRQ_MASK);
      if (wr_halt) halt_q <= masked(i_wdata, BIT0_MASK);
      if (wr_freq_correction) freq_correction_q <= i_wdata;
      if (wr_source) source_q <= masked(i_wdata, SOURCE_MASK);
      if (wr_pit_ctrl) pit_ctrl_q <= masked(i_wdata, PIT_CTRL_MASK);
      if (wr_pit_ien) pit_ien_q <= masked(i_wdata, BIT0_MASK);
      if (wr_pit_halt) pit_halt_q <= masked(i_wdata, BIT0_MASK);
    end
  end

  // Shared byte: low half staged, high half completes the word
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shared_q   <= BYTE_RST;
      cnt_load_q <= WORD_RST;
      limit_q    <= LIMIT_RST;
      match_q    <= WORD_RST;
    end else begin
      if (wr_shared || wr_lo) begin
        shared_q <= i_wdata;
      end else if (rd_cnt_lo) begin
        shared_q <= cnt_q[15:8];
      end else if (rd_limit_lo) begin
        shared_q <= limit_q[15:8];
      end else if (rd_match_lo) begin
        shared_q <= match_q[15:8];
      end
      if (wr_ch[CH_COUNT]) cnt_load_q <= {i_wdata, shared_q};
      if (wr_ch[CH_LIMIT]) limit_q <= {i_wdata, shared_q};
      if (wr_ch[CH_MATCH]) match_q <= {i_wdata, shared_q};
    end
  end

  // Staged writes take effect on the second counter clock edge
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      apply[i] = busy_q[i] && tick_bus.edge_tick && !wr_ch[i] &&
                 (age_q[i] == SYNC_LAST);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        age_q[i] <= 2'd0;
      end
    end else if (i_clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_ch[i]) begin
          busy_q[i] <= 1'b1;
          age_q[i]  <= 2'd0;
        end else if (apply[i]) begin
          busy_q[i] <= 1'b0;
        end else if (busy_q[i] && tick_bus.edge_tick) begin
          age_q[i] <= age_q[i] + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_eff_q  <= BYTE_RST;
      limit_eff_q <= LIMIT_RST;
      match_eff_q <= WORD_RST;
    end else begin
      if (apply[CH_CTRL]) ctrl_eff_q <= ctrl_q;
      if (apply[CH_LIMIT]) limit_eff_q <= limit_q;
      if (apply[CH_MATCH]) match_eff_q <= match_q;
    end
  end

  // Run gating and prescaler setup
  assign tick_bus.run = ctrl_eff_q[CTRL_ON] &&
                        !(i_standby && !ctrl_eff_q[CTRL_KEEP_RUN]) &&
                        !(i_cpu_halted && !halt_q[HALT_RUN]);
  assign tick_bus.presc_sel = ctrl_eff_q[CTRL_PRESC_HI:CTRL_PRESC_LO];
  assign tick_bus.corr_on   = ctrl_eff_q[CTRL_CORR];
  assign tick_bus.freq_correction     = freq_correction_q;

  // Counter
  assign advance   = tick_bus.presc_tick && !apply[CH_COUNT];
  assign cnt_nxt   = (cnt_q == limit_eff_q) ? WORD_RST : cnt_q + 16'd1;
  assign wrap_hit  = advance && (cnt_q == limit_eff_q);
  assign match_hit = advance && (cnt_nxt == match_eff_q);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= WORD_RST;
    end else if (i_clk_en) begin
      if (apply[CH_COUNT]) begin
        cnt_q <= cnt_load_q;
      end else if (advance) begin
        cnt_q <= cnt_nxt;
      end
    end
  end

  // Flags: a new event wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q     <= BYTE_RST;
      wrap_q      <= 1'b0;
      match_evt_q <= 1'b0;
    end else if (i_clk_en) begin
      flags_q <= (flags_q & ~(wr_flags ? masked(i_wdata, IRQ_MASK) : 8'h00))
                 | {6'h00, match_hit, wrap_hit};
      wrap_q      <= wrap_hit;
      match_evt_q <= match_hit;
    end
  end

  assign o_irq_req = (flags_q[IRQ_MATCH] && ien_q[IRQ_MATCH]) ||
                     (flags_q[IRQ_WRAP] && ien_q[IRQ_WRAP]);
  assign o_wrap_evt      = wrap_q;
  assign o_match_evt     = match_evt_q;
  assign o_clk_source    = source_q[1:0];
  assign o_periodic_ctrl = pit_ctrl_q;

  // Read mux
  always_comb begin
    rd_d = 8'h00;
    if (i_addr == OFF_CTRL) begin
      rd_d = ctrl_q;
    end else if (i_addr == OFF_STATUS) begin
      rd_d = {4'h0, busy_q};
    end else if (i_addr == OFF_IRQ_EN) begin
      rd_d = ien_q;
    end else if (i_addr == OFF_IRQ_FLAGS) begin
      rd_d = flags_q;
    end else if (i_addr == OFF_SHARED) begin
      rd_d = shared_q;
    end else if (i_addr == OFF_HALT) begin
      rd_d = halt_q;
    end else if (i_addr == OFF_FREQ_CORRECTION) begin
      rd_d = freq_correction_q;
    end else if (i_addr == OFF_SOURCE) begin
      rd_d = source_q;
    end else if (i_addr == OFF_COUNT_LO) begin
      rd_d = cnt_q[7:0];
    end else if (i_addr == OFF_LIMIT_LO) begin
      rd_d = limit_q[7:0];
    end else if (i_addr == OFF_MATCH_LO) begin
      rd_d = match_q[7:0];
    end else if (i_addr == OFF_COUNT_HI || i_addr == OFF_LIMIT_HI ||
                 i_addr == OFF_MATCH_HI) begin
      rd_d = shared_q;
    end else if (i_addr == OFF_PIT_CTRL) begin
      rd_d = pit_ctrl_q;
    end else if (i_addr == OFF_PIT_IEN) begin
      rd_d = pit_ien_q;
    end else if (i_addr == OFF_PIT_HALT) begin
      rd_d = pit_halt_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_clk_en) begin
      rdata_q <= i_rd ? rd_d : 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_ctrl_held_busy: assert property (
    busy_q[CH_CTRL] && !apply[CH_CTRL] |=> $stable(ctrl_eff_q))
    else $error("control applied before sync finished");
  a_ctrl_busy_flag: assert property (
    wr_ctrl |=> busy_q[CH_CTRL] && ctrl_q == ($past(i_wdata) & CTRL_MASK))
    else $error("control busy not raised");
  a_match_busy_flag: assert property (
    wr_ch[CH_MATCH] |=> busy_q[CH_MATCH] && match_eff_q == $past(match_eff_q))
    else $error("compare busy not raised");
  a_limit_applied: assert property (
    $fell(busy_q[CH_LIMIT]) |-> limit_eff_q == limit_q)
    else $error("period not applied when busy fell");
  a_count_loaded: assert property (
    apply[CH_COUNT] && i_clk_en |=> cnt_q == $past(cnt_load_q))
    else $error("count not loaded after sync");
  a_div1_tick: assert property (
    tick_bus.run && tick_bus.presc_sel == 4'h0 && !tick_bus.corr_on
    |-> tick_bus.presc_tick == tick_bus.edge_tick)
    else $error("undivided prescaler missed a tick");
  a_standby_stop: assert property (
    i_standby && !ctrl_eff_q[CTRL_KEEP_RUN] && !apply[CH_COUNT]
    |=> $stable(cnt_q))
    else $error("counter moved in standby");
  a_off_stop: assert property (
    !ctrl_eff_q[CTRL_ON] |-> !tick_bus.presc_tick)
    else $error("counter ticked while off");
  a_match_flag: assert property (
    match_hit && i_clk_en |=> flags_q[IRQ_MATCH] && o_match_evt)
    else $error("compare flag not set");
  a_wrap_zero: assert property (
    wrap_hit && i_clk_en |=> cnt_q == WORD_RST && flags_q[IRQ_WRAP])
    else $error("wrap did not clear count");
  a_flag_clear: assert property (
    wr_flags && i_wdata[IRQ_WRAP] && !wrap_hit |=> !flags_q[IRQ_WRAP])
    else $error("flag not cleared by one");
  a_irq_gate: assert property (
    !ien_q[IRQ_MATCH] && !ien_q[IRQ_WRAP] |-> !o_irq_req)
    else $error("request while disabled");
  a_irq_wrap: assert property (
    flags_q[IRQ_WRAP] && ien_q[IRQ_WRAP] |-> o_irq_req)
    else $error("wrap request missing");
  a_event_flag: assert property (
    o_wrap_evt |-> flags_q[IRQ_WRAP] && $past(wrap_hit))
    else $error("wrap event without flag");
  a_word_pair: assert property (
    wr_ch[CH_MATCH] |=> match_q == {$past(i_wdata), $past(shared_q)})
    else $error("word not paired with shared byte");
  a_step_one: assert property (
    advance && i_clk_en && cnt_q != limit_eff_q
    |=> cnt_q == $past(cnt_q) + 16'd1)
    else $error("count did not step by one");
  a_status_zero: assert property (
    i_rd && i_clk_en && i_addr == OFF_STATUS |=> o_rdata[7:4] == 4'h0)
    else $error("unused status bits not zero");

  c_wrap: cover property (o_wrap_evt);
  c_match: cover property (o_match_evt);
  c_ctrl_apply: cover property (apply[CH_CTRL]);
  c_word_read: cover property (rd_cnt_lo ##1 i_rd && i_addr == OFF_COUNT_HI);
endmodule

/* pkg/rtc_pkg.sv */
// Shared constants of the real-time counter register block.
// Assumes a byte-wide register port with a five-bit address.
package rtc_pkg;
  // Port widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [4:0] OFF_CTRL      = 5'h00;
  localparam logic [4:0] OFF_STATUS    = 5'h01;
  localparam logic [4:0] OFF_IRQ_EN    = 5'h02;
  localparam logic [4:0] OFF_IRQ_FLAGS = 5'h03;
  localparam logic [4:0] OFF_SHARED    = 5'h04;
  localparam logic [4:0] OFF_HALT      = 5'h05;
  localparam logic [4:0] OFF_FREQ_CORRECTION     = 5'h06;
  localparam logic [4:0] OFF_SOURCE    = 5'h07;
  localparam logic [4:0] OFF_COUNT_LO  = 5'h08;
  localparam logic [4:0] OFF_COUNT_HI  = 5'h09;
  localparam logic [4:0] OFF_LIMIT_LO  = 5'h0a;
  localparam logic [4:0] OFF_LIMIT_HI  = 5'h0b;
  localparam logic [4:0] OFF_MATCH_LO  = 5'h0c;
  localparam logic [4:0] OFF_MATCH_HI  = 5'h0d;
  localparam logic [4:0] OFF_PIT_CTRL  = 5'h10;
  localparam logic [4:0] OFF_PIT_STAT  = 5'h11;
  localparam logic [4:0] OFF_PIT_IEN   = 5'h12;
  localparam logic [4:0] OFF_PIT_FLAG  = 5'h13;
  localparam logic [4:0] OFF_PIT_HALT  = 5'h15;
  // Field positions
  localparam int unsigned CTRL_KEEP_RUN = 7;
  localparam int unsigned CTRL_PRESC_HI = 6;
  localparam int unsigned CTRL_PRESC_LO = 3;
  localparam int unsigned CTRL_CORR     = 2;
  localparam int unsigned CTRL_ON       = 0;
  localparam int unsigned CH_CTRL       = 0;
  localparam int unsigned CH_COUNT      = 1;
  localparam int unsigned CH_LIMIT      = 2;
  localparam int unsigned CH_MATCH      = 3;
  localparam int unsigned IRQ_WRAP      = 0;
  localparam int unsigned IRQ_MATCH     = 1;
  localparam int unsigned FREQ_CORRECTION_SIGN    = 7;
  localparam int unsigned HALT_RUN      = 0;
  // Writable bit masks
  localparam logic [7:0] CTRL_MASK     = 8'hfd;
  localparam logic [7:0] IRQ_MASK      = 8'h03;
  localparam logic [7:0] BIT0_MASK     = 8'h01;
  localparam logic [7:0] SOURCE_MASK   = 8'h03;
  localparam logic [7:0] PIT_CTRL_MASK = 8'h79;
  // Reset values
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  // Counter clock edges before a staged write takes effect
  localparam logic [1:0] SYNC_TICKS = 2'd2;
  localparam logic [1:0] SYNC_LAST  = SYNC_TICKS - 2'd1;
  // Counter clock cycles per correction interval
  localparam int unsigned PPM_INTERVAL = 1000000;
endpackage

/* pkg/rtc_tick_if.sv */
// Tick and prescaler signals between the counter core and its helpers.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface rtc_tick_if;
  logic       edge_tick;
  logic       run;
  logic [3:0] presc_sel;
  logic       corr_on;
  logic [7:0] freq_correction;
  logic       presc_tick;
  modport src   (output edge_tick);
  modport presc (input edge_tick, run, presc_sel, corr_on, freq_correction,
                 output presc_tick);
  modport core  (input edge_tick, presc_tick,
                 output run, presc_sel, corr_on, freq_correction);
endinterface

/* hdl/counter_clk_sync.sv */
// Synchroniser and rising-edge detector for the counter clock pin.
// Assumes the pin toggles well below half the system clock rate.
`timescale 1ns/1ps
module counter_clk_sync
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  // Counter clock pin
  input  wire logic i_pin,
  // Tick output
  rtc_tick_if.src   bus
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (i_clk_en) begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // One pulse per counter clock rising edge
  assign bus.edge_tick = i_clk_en & sync_q & ~prev_q;
endmodule

/* hdl/prescaler_corr.sv */
// Power-of-two prescaler with spread parts-per-million correction.
// Assumes edge_tick pulses once per counter clock edge.
`timescale 1ns/1ps
module prescaler_corr
  import rtc_pkg::*;
#(
  parameter int unsigned PPM_CYCLES = PPM_INTERVAL
)(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  // Tick signals
  rtc_tick_if.presc bus
);
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [19:0] acc_q;
  logic [19:0] acc_sum;
  logic        hit;
  logic [1:0]  step;

  assign acc_sum = acc_q + {13'd0, bus.freq_correction[6:0]};
  assign hit     = bus.corr_on && (acc_sum >= 20'(PPM_CYCLES));
  // Positive error skips a step, negative error adds one
  always_comb begin
    step = 2'd1;
    if (hit) begin
      step = bus.freq_correction[FREQ_CORRECTION_SIGN] ? 2'd2 : 2'd0;
    end
  end
  assign div_d = div_q + {14'd0, step};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= WORD_RST;
      acc_q <= 20'h00000;
    end else if (i_clk_en && bus.edge_tick && bus.run) begin
      div_q <= div_d;
      if (!bus.corr_on) begin
        acc_q <= 20'h00000;
      end else if (hit) begin
        acc_q <= acc_sum - 20'(PPM_CYCLES);
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  // Tick on carry out of the low prescaler bits
  assign bus.presc_tick = bus.edge_tick && bus.run &&
    ((div_q >> bus.presc_sel) != (div_d >> bus.presc_sel));
endmodule

/* dv/rtc_control_status_regs_bench.sv */
// Self-checking bench for the counter control and status registers.
// Assumes the design package and a 10 MHz system clock.
`timescale 1ns/1ps
module rtc_control_status_regs_bench;
  import rtc_pkg::*;
  logic              i_clock;
  logic              i_rst_n;
  logic              i_wr;
  logic              i_rd;
  logic              i_counter_clk;
  logic              i_standby;
  logic              i_cpu_halted;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] o_rdata;
  logic              o_irq_req;
  logic              o_wrap_evt;
  logic              o_match_evt;
  logic [1:0]        o_clk_source;
  logic [7:0]        o_periodic_ctrl;
  logic [20:0]       rows [0:8];
  logic              i_clk_en;
  int                err_total;
  int                cmp_count;
  int                n;

  rtc_control_status_regs #(.PPM_CYCLES(64)) rtc_control_status_regs_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_counter_clk(i_counter_clk),
    .i_standby(i_standby), .i_cpu_halted(i_cpu_halted),
    .o_irq_req(o_irq_req), .o_wrap_evt(o_wrap_evt),
    .o_match_evt(o_match_evt), .o_clk_source(o_clk_source),
    .o_periodic_ctrl(o_periodic_ctrl));

  // Clocks: system 100 ns, counter clock 16 system cycles
  always #50 i_clock = ~i_clock;
  always #800 i_counter_clk = ~i_counter_clk;

  task automatic final_report;
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask

  // Poll status until every busy bit has cleared
  task automatic idle;
    int         k;
    logic [7:0] v;
    k = 0;
    do begin
      rd(OFF_STATUS, v);
      k++;
    end while (v !== 8'h00 && k < 100);
    chk({8'h00, v}, 16'h0000);
  endtask

  task automatic wait_evt(input bit m, output int c);
    c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (((m ? o_match_evt : o_wrap_evt) !== 1'b1) && c < 3000);
  endtask

  task automatic count_evt(output int c);
    c = 0;
    repeat (400) begin
      @(posedge i_clock);
      #1;
      if (o_wrap_evt === 1'b1) c++;
    end
  endtask

  // Watchdog
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  initial begin
    i_clock = 1'b0;
    i_counter_clk = 1'b0;
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_standby = 1'b0;
    i_cpu_halted = 1'b0;
    i_clk_en = 1'b1;
    i_addr = 5'h00;
    i_wdata = 8'h00;
    err_total = 0;
    cmp_count = 0;
    rows = '{{5'h02, 8'hff, 8'h03}, {5'h03, 8'hff, 8'h00},
             {5'h01, 8'hff, 8'h00}, {5'h04, 8'ha5, 8'ha5},
             {5'h05, 8'hff, 8'h01}, {5'h06, 8'h83, 8'h83},
             {5'h07, 8'hff, 8'h03}, {5'h0e, 8'hff, 8'h00},
             {5'h10, 8'hff, 8'h79}};
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    // Write and read back each row
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rchk(rows[i][20:16], rows[i][7:0]);
    end
    chk({14'h0000, o_clk_source}, 16'h0003);
    chk({8'h00, o_periodic_ctrl}, 16'h0079);
    // Reset in mid-run
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(i[4:0], 8'h00);
    rchk(OFF_LIMIT_LO, 8'hff);
    rchk(OFF_LIMIT_HI, 8'hff);
    chk({14'h0000, o_clk_source}, 16'h0000);
    // Period 3, compare 2, count 0
    wr(OFF_LIMIT_LO, 8'h03);
    wr(OFF_LIMIT_HI, 8'h00);
    rchk(OFF_STATUS, 8'h04);
    idle();
    wr(OFF_MATCH_LO, 8'h02);
    wr(OFF_MATCH_HI, 8'h00);
    rchk(OFF_STATUS, 8'h08);
    idle();
    wr(OFF_COUNT_LO, 8'h00);
    wr(OFF_COUNT_HI, 8'h00);
    rchk(OFF_STATUS, 8'h02);
    idle();
    rchk(OFF_LIMIT_LO, 8'h03);
    rchk(OFF_LIMIT_HI, 8'h00);
    wr(OFF_IRQ_EN, 8'h03);
    // Two ticks from wrap to match and back, for prescaler settings 0 to 2
    for (int p = 0; p < 3; p++) begin
      wr(OFF_CTRL, {1'b0, p[3:0], 3'b001});
      rchk(OFF_STATUS, 8'h01);
      idle();
      wait_evt(1'b0, n);
      wait_evt(1'b1, n);
      chk(n[15:0], 16'(32 << p));
      wait_evt(1'b0, n);
      chk(n[15:0], 16'(32 << p));
    end
    // Correction of 32 per 64 edges halves the tick rate
    wr(OFF_FREQ_CORRECTION, 8'h20);
    wr(OFF_CTRL, 8'h05);
    idle();
    wait_evt(1'b0, n);
    wait_evt(1'b1, n);
    chk(n[15:0], 16'h0040);
    rchk(OFF_IRQ_FLAGS, 8'h03);
    chk({15'h0000, o_irq_req}, 16'h0001);
    // Standby stops the counter unless told to keep running
    wr(OFF_CTRL, 8'h01);
    idle();
    @(posedge i_clock);
    i_standby <= 1'b1;
    count_evt(n);
    chk(n[15:0], 16'h0000);
    wr(OFF_CTRL, 8'h81);
    idle();
    count_evt(n);
    chk({15'h0000, n > 5}, 16'h0001);
    @(posedge i_clock);
    i_standby <= 1'b0;
    i_cpu_halted <= 1'b1;
    count_evt(n);
    chk(n[15:0], 16'h0000);
    @(posedge i_clock);
    i_cpu_halted <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    idle();
    // Count load and atomic readback while stopped
    wr(OFF_COUNT_LO, 8'h34);
    wr(OFF_COUNT_HI, 8'h12);
    idle();
    rchk(OFF_COUNT_LO, 8'h34);
    rchk(OFF_COUNT_HI, 8'h12);
    // Strobe lost while clock enable is low
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    wr(OFF_SHARED, 8'h5a);
    i_clk_en <= 1'b1;
    rchk(OFF_SHARED, 8'h12);
    // Flag clearing and enable gating
    wr(OFF_IRQ_EN, 8'h01);
    #1 chk({15'h0000, o_irq_req}, 16'h0001);
    wr(OFF_IRQ_FLAGS, 8'h01);
    #1 chk({15'h0000, o_irq_req}, 16'h0000);
    rchk(OFF_IRQ_FLAGS, 8'h02);
    wr(OFF_IRQ_FLAGS, 8'h00);
    rchk(OFF_IRQ_FLAGS, 8'h02);
    wr(OFF_IRQ_EN, 8'h02);
    #1 chk({15'h0000, o_irq_req}, 16'h0001);
    wr(OFF_IRQ_FLAGS, 8'h02);
    rchk(OFF_IRQ_FLAGS, 8'h00);
    chk({15'h0000, o_irq_req}, 16'h0000);
    final_report();
  end
endmodule
